// ### core/dss_map.vh
// Constants for the start, stop, shutoff and second-function input logic
`ifndef DSS_MAP_VH
`define DSS_MAP_VH
`define DSS_CLK_MHZ 25
`define DSS_FILT_US 100
`define DSS_FILT_CYC (`DSS_FILT_US * `DSS_CLK_MHZ)
`define DSS_CYC_PER_SEC 25000000
`define DSS_NUM_TERM 7
`define DSS_FUNC_W 14
`define DSS_SET_W 16
`define DSS_SEL_W 5
`define DSS_NUM_SET 22
// Function codes
`define DSS_FN_SHUTOFF 14'd24
`define DSS_FN_SECOND 14'd3
`define DSS_FN_FWD 14'd60
`define DSS_FN_REV 14'd61
// Stop-method codes and ranges
`define DSS_SM_DECEL 16'd9999
`define DSS_SM_DECEL_DIR 16'd8888
`define DSS_SM_LOW_MAX 16'd100
`define DSS_SM_HI_MIN 16'd1000
`define DSS_SM_HI_MAX 16'd1100
`define DSS_SM_OFFSET 16'd1000
`define DSS_ALT_SAME 16'd9999
// Setting store indices
`define DSS_IX_STOP 5'd0
`define DSS_IX_TB 5'd1
`define DSS_IX_BF 5'd2
`define DSS_IX_AT 5'd3
`define DSS_IX_DT 5'd4
`define DSS_IX_TH 5'd5
`define DSS_IX_ST 5'd6
`define DSS_IX_MT 5'd7
`define DSS_IX_ALT_TB 5'd8
`define DSS_IX_ALT_BF 5'd9
`define DSS_IX_ALT_AT 5'd10
`define DSS_IX_ALT_DT 5'd11
`define DSS_IX_ALT_TH 5'd12
`define DSS_IX_ALT_ST 5'd13
`define DSS_IX_ALT_MT 5'd14
`define DSS_IX_TERM0 5'd15
// Reset values
`define DSS_RST_STOP 16'd9999
`define DSS_RST_ALT_DT 16'd9999
`define DSS_RST_TERM0 16'd60
`define DSS_RST_TERM1 16'd61
`define DSS_RST_TERM2 16'd24
`define DSS_RST_TERM3 16'd3
`define DSS_RST_NONE 16'd9999
`define DSS_RST_ZERO 16'h0000
`endif

// ### core/dss_infilt.v
// Two-stage synchroniser with a stability filter for one terminal input
`timescale 1ns/100ps
module dss_infilt #(
  parameter FILT_CYC = 2500
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Raw and filtered level
  input wire din,
  output reg dout
);
  reg meta_ff;
  reg sync_ff;
  reg [11:0] cnt_ff;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      cnt_ff <= 12'h000;
      dout <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      // Level must hold for the whole window before it is passed on
      if (sync_ff == dout)
        cnt_ff <= 12'h000;
      else if (cnt_ff == FILT_CYC[11:0] - 12'h001)
      begin
        cnt_ff <= 12'h000;
        dout <= sync_ff;
      end
      else
        cnt_ff <= cnt_ff + 12'h001;
    end
  end
endmodule // dss_infilt

// ### core/dss_top.v
// Start/stop, output-shutoff and second-function input decoding
`timescale 1ns/100ps
`include "dss_map.vh"
module dss_top #(
  parameter CYC_PER_SEC = `DSS_CYC_PER_SEC
) (
  // Clock and reset
  input wire CLK,
  input wire RSTN,
  // Terminals
  input wire [`DSS_NUM_TERM-1:0] TERM_IN,
  input wire COMM_SHUTOFF_IN,
  input wire NET_MODE,
  // Setting write port
  input wire SET_WR_EN,
  input wire [`DSS_SEL_W-1:0] SET_WR_SEL,
  input wire [`DSS_SET_W-1:0] SET_WR_DATA,
  input wire [`DSS_SET_W-1:0] USER_GROUP_READ_SELECT,
  output reg SET_WR_REFUSED,
  // Drive feedback
  input wire MOTOR_STOPPED,
  // Drive commands
  output reg RUN_REQ,
  output reg DIR_REVERSE,
  output reg DECEL_REQ,
  output reg OUTPUT_SHUTOFF,
  output reg SECOND_FUNC_ACTIVE,
  // Active drive settings
  output reg [`DSS_SET_W-1:0] ACT_TORQUE_BOOST,
  output reg [`DSS_SET_W-1:0] ACT_BASE_FREQ,
  output reg [`DSS_SET_W-1:0] ACT_ACCEL_TIME,
  output reg [`DSS_SET_W-1:0] ACT_DECEL_TIME,
  output reg [`DSS_SET_W-1:0] ACT_THERMAL_LEVEL,
  output reg [`DSS_SET_W-1:0] ACT_STALL_LEVEL,
  output reg [`DSS_SET_W-1:0] ACT_MOTOR_TYPE
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_DECEL = 2'd2;
  localparam ST_COAST = 2'd3;

  reg [`DSS_SET_W-1:0] set_ff [0:`DSS_NUM_SET-1];
  wire [`DSS_NUM_TERM-1:0] term_flt;
  wire [`DSS_NUM_TERM-1:0] hit_shut;
  wire [`DSS_NUM_TERM-1:0] hit_sec;
  wire [`DSS_NUM_TERM-1:0] hit_fwd;
  wire [`DSS_NUM_TERM-1:0] hit_rev;

  function [`DSS_SET_W-1:0] rst_val;
    input integer ix;
    begin
      case (ix)
        0: rst_val = `DSS_RST_STOP;
        11: rst_val = `DSS_RST_ALT_DT;
        15: rst_val = `DSS_RST_TERM0;
        16: rst_val = `DSS_RST_TERM1;
        17: rst_val = `DSS_RST_TERM2;
        18: rst_val = `DSS_RST_TERM3;
        19, 20, 21: rst_val = `DSS_RST_NONE;
        default: rst_val = `DSS_RST_ZERO;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `DSS_NUM_SET; g = g + 1)
    begin : g_set
      always @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
          set_ff[g] <= rst_val(g);
        else if (SET_WR_EN && SET_WR_SEL == g && USER_GROUP_READ_SELECT == 16'h0000)
          set_ff[g] <= SET_WR_DATA;
      end
    end
    for (g = 0; g < `DSS_NUM_TERM; g = g + 1)
    begin : g_term
      wire [`DSS_FUNC_W-1:0] fn;
      assign fn = set_ff[`DSS_IX_TERM0 + g][`DSS_FUNC_W-1:0];
      dss_infilt #(.FILT_CYC(`DSS_FILT_CYC)) u_filt (
        .clk(CLK),
        .rstn(RSTN),
        .din(TERM_IN[g]),
        .dout(term_flt[g])
      );
      // Same function on several terminals is ORed below
      assign hit_shut[g] = term_flt[g] && fn == `DSS_FN_SHUTOFF;
      assign hit_sec[g] = term_flt[g] && fn == `DSS_FN_SECOND;
      assign hit_fwd[g] = term_flt[g] && fn == `DSS_FN_FWD;
      assign hit_rev[g] = term_flt[g] && fn == `DSS_FN_REV;
    end
  endgenerate

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      SET_WR_REFUSED <= 1'b0;
    else
      SET_WR_REFUSED <= SET_WR_EN && USER_GROUP_READ_SELECT != 16'h0000;
  end

  // Stop-method decode
  wire [`DSS_SET_W-1:0] sm = set_ff[`DSS_IX_STOP];
  wire sm_low = sm <= `DSS_SM_LOW_MAX;
  wire sm_hi = sm >= `DSS_SM_HI_MIN && sm <= `DSS_SM_HI_MAX;
  wire sm_timed = sm_low || sm_hi;
  wire dir_mode = sm_hi || sm == `DSS_SM_DECEL_DIR;
  wire [`DSS_SET_W-1:0] coast_sec = sm_hi ? sm - `DSS_SM_OFFSET : sm;

  wire fwd = |hit_fwd;
  wire rev = |hit_rev;
  // Terminal shutoff is never gated by mode; communication only in network mode
  wire shut = (|hit_shut) || (COMM_SHUTOFF_IN && NET_MODE);
  wire sec = |hit_sec;

  reg start_c;
  reg rev_c;
  always @*
  begin
    if (dir_mode)
    begin
      start_c = fwd;
      rev_c = rev;
    end
    else
    begin
      start_c = fwd ^ rev;
      rev_c = rev && !fwd;
    end
  end

  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [24:0] pre_ff;
  reg [`DSS_SET_W-1:0] sec_ff;
  wire tick = pre_ff == CYC_PER_SEC[24:0] - 25'd1;
  wire expired = sec_ff >= coast_sec;

  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (start_c && !shut)
          nxt_st = ST_RUN;
      ST_RUN:
        if (shut)
          nxt_st = ST_COAST;
        else if (!start_c)
          nxt_st = (sm_timed && coast_sec == 16'h0000) ? ST_COAST : ST_DECEL;
      ST_DECEL:
        if (shut || (sm_timed && expired))
          nxt_st = ST_COAST;
        else if (start_c)
          nxt_st = ST_RUN;
        else if (MOTOR_STOPPED)
          nxt_st = ST_IDLE;
      ST_COAST:
        if (MOTOR_STOPPED && !start_c)
          nxt_st = ST_IDLE;
      default:
        nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_ff <= ST_IDLE;
      pre_ff <= 25'd0;
      sec_ff <= 16'h0000;
      RUN_REQ <= 1'b0;
      DIR_REVERSE <= 1'b0;
      DECEL_REQ <= 1'b0;
      OUTPUT_SHUTOFF <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      // Seconds count from the start removal only
      if (nxt_st != ST_DECEL || st_ff != ST_DECEL)
      begin
        pre_ff <= 25'd0;
        sec_ff <= 16'h0000;
      end
      else if (tick)
      begin
        pre_ff <= 25'd0;
        sec_ff <= sec_ff + 16'h0001;
      end
      else
        pre_ff <= pre_ff + 25'd1;
      RUN_REQ <= nxt_st == ST_RUN;
      if (nxt_st == ST_RUN)
        DIR_REVERSE <= rev_c;
      DECEL_REQ <= nxt_st == ST_DECEL;
      // Shutoff also interlocks a start while idle
      OUTPUT_SHUTOFF <= nxt_st == ST_COAST || shut;
    end
  end

  // Alternate decel of 9999 follows the alternate accel time
  wire [`DSS_SET_W-1:0] alt_dt = (set_ff[`DSS_IX_ALT_DT] == `DSS_ALT_SAME) ?
    set_ff[`DSS_IX_ALT_AT] : set_ff[`DSS_IX_ALT_DT];

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SECOND_FUNC_ACTIVE <= 1'b0;
      ACT_TORQUE_BOOST <= `DSS_RST_ZERO;
      ACT_BASE_FREQ <= `DSS_RST_ZERO;
      ACT_ACCEL_TIME <= `DSS_RST_ZERO;
      ACT_DECEL_TIME <= `DSS_RST_ZERO;
      ACT_THERMAL_LEVEL <= `DSS_RST_ZERO;
      ACT_STALL_LEVEL <= `DSS_RST_ZERO;
      ACT_MOTOR_TYPE <= `DSS_RST_ZERO;
    end
    else
    begin
      SECOND_FUNC_ACTIVE <= sec;
      ACT_TORQUE_BOOST <= sec ? set_ff[`DSS_IX_ALT_TB] : set_ff[`DSS_IX_TB];
      ACT_BASE_FREQ <= sec ? set_ff[`DSS_IX_ALT_BF] : set_ff[`DSS_IX_BF];
      ACT_ACCEL_TIME <= sec ? set_ff[`DSS_IX_ALT_AT] : set_ff[`DSS_IX_AT];
      ACT_DECEL_TIME <= sec ? alt_dt : set_ff[`DSS_IX_DT];
      ACT_THERMAL_LEVEL <= sec ? set_ff[`DSS_IX_ALT_TH] : set_ff[`DSS_IX_TH];
      ACT_STALL_LEVEL <= sec ? set_ff[`DSS_IX_ALT_ST] : set_ff[`DSS_IX_ST];
      ACT_MOTOR_TYPE <= sec ? set_ff[`DSS_IX_ALT_MT] : set_ff[`DSS_IX_MT];
    end
  end
endmodule // dss_top

// ### dv/dss_top_assertions.sv
// Checker for the start/stop, shutoff and second-function decoder
`timescale 1ns/100ps
`include "dss_map.vh"
module dss_chk (
  // Clock and reset
  input wire CLK,
  input wire RSTN,
  // Inputs
  input wire [`DSS_NUM_TERM-1:0] TERM_IN,
  input wire SET_WR_EN,
  input wire [`DSS_SET_W-1:0] USER_GROUP_READ_SELECT,
  input wire MOTOR_STOPPED,
  // Outputs
  input wire SET_WR_REFUSED,
  input wire RUN_REQ,
  input wire DECEL_REQ,
  input wire OUTPUT_SHUTOFF,
  input wire SECOND_FUNC_ACTIVE
);
  reg [6:0] prev_ff;
  reg [11:0] calm_ff;
  // Saturates well above the filter length
  always @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      prev_ff <= 7'h00;
      calm_ff <= 12'h000;
    end
    else
    begin
      prev_ff <= TERM_IN;
      calm_ff <= (TERM_IN != prev_ff) ? 12'h000 : (calm_ff == 12'hfff) ? calm_ff : calm_ff + 12'h001;
    end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_refuse_pulse: assert property (SET_WR_EN && USER_GROUP_READ_SELECT != 16'h0000 |=> SET_WR_REFUSED)
    else $error("refused write not flagged");
  a_accept_quiet: assert property (SET_WR_EN && USER_GROUP_READ_SELECT == 16'h0000 |=> !SET_WR_REFUSED)
    else $error("accepted write flagged");
  a_shut_no_run: assert property (OUTPUT_SHUTOFF |-> !RUN_REQ)
    else $error("running under shutoff");
  a_coast_no_decel: assert property ($fell(RUN_REQ) && OUTPUT_SHUTOFF |-> !DECEL_REQ)
    else $error("shutoff decelerates");
  a_decel_entry: assert property ($rose(DECEL_REQ) |-> $past(RUN_REQ))
    else $error("decel not from run");
  a_decel_exit: assert property ($fell(DECEL_REQ) |-> RUN_REQ || OUTPUT_SHUTOFF || $past(MOTOR_STOPPED))
    else $error("decel left without cause");
  a_filter_run: assert property ($rose(RUN_REQ) |-> calm_ff >= 12'd2500)
    else $error("start acted on unfiltered input");
  a_filter_second: assert property ($changed(SECOND_FUNC_ACTIVE) |-> calm_ff >= 12'd2500)
    else $error("second function unfiltered");
endmodule // dss_chk
bind dss_top dss_chk u_chk (.CLK(CLK), .RSTN(RSTN), .TERM_IN(TERM_IN), .SET_WR_EN(SET_WR_EN),
  .USER_GROUP_READ_SELECT(USER_GROUP_READ_SELECT), .MOTOR_STOPPED(MOTOR_STOPPED), .SET_WR_REFUSED(SET_WR_REFUSED),
  .RUN_REQ(RUN_REQ), .DECEL_REQ(DECEL_REQ), .OUTPUT_SHUTOFF(OUTPUT_SHUTOFF), .SECOND_FUNC_ACTIVE(SECOND_FUNC_ACTIVE));

// ### dv/dss_term_model.sv
// Far-side model: contact closures on the terminal block
`timescale 1ns/100ps
module dss_term_model (
  // Contacts
  input wire fwd,
  input wire rev,
  input wire shut,
  input wire second,
  input wire [2:0] aux,
  // Terminal levels
  output wire [6:0] term
);
  // Wired as the reset terminal assignment
  assign term = {aux, second, shut, rev, fwd};
endmodule // dss_term_model

// ### dv/dss_top_tb.sv
// Self-checking bench for the start/stop, shutoff and second-function decoder
`timescale 1ns/100ps
module drive_start_stop_input_logic_tb;
  localparam CPS = 10;
  reg clk = 0, rstn = 0, fwd = 0, rev = 0, shut = 0, sec = 0, net = 0, comm = 0, stp = 0, wen = 0, rf = 0;
  reg [2:0] aux = 3'h0;
  reg [4:0] wsel = 5'h00;
  reg [15:0] wdat = 16'h0000, ugrs = 16'h0000, val [0:14];
  integer n_errors = 0, cmp_count = 0, cyc = 0, i, k, n, c, seed;
  wire [6:0] term;
  wire refused, run, dir, decel, shutoff, second;
  wire [15:0] act [0:6];
  always #20 clk = ~clk;
  dss_term_model far (.fwd(fwd), .rev(rev), .shut(shut), .second(sec), .aux(aux), .term(term));
  dss_top #(.CYC_PER_SEC(CPS)) dut (.CLK(clk), .RSTN(rstn), .TERM_IN(term), .COMM_SHUTOFF_IN(comm),
    .NET_MODE(net), .SET_WR_EN(wen), .SET_WR_SEL(wsel), .SET_WR_DATA(wdat), .USER_GROUP_READ_SELECT(ugrs),
    .SET_WR_REFUSED(refused), .MOTOR_STOPPED(stp), .RUN_REQ(run), .DIR_REVERSE(dir), .DECEL_REQ(decel),
    .OUTPUT_SHUTOFF(shutoff), .SECOND_FUNC_ACTIVE(second), .ACT_TORQUE_BOOST(act[0]), .ACT_BASE_FREQ(act[1]),
    .ACT_ACCEL_TIME(act[2]), .ACT_DECEL_TIME(act[3]), .ACT_THERMAL_LEVEL(act[4]), .ACT_STALL_LEVEL(act[5]),
    .ACT_MOTOR_TYPE(act[6]));
  task print_verdict;
    begin
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task tick(input integer m);
    begin
      repeat (m) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [8*8-1:0] name, input [15:0] e, input [15:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s exp %h got %h", name, e, g);
      end
    end
  endtask
  task cmd(input [3:0] e);
    chk("cmd", {12'h000, e}, {12'h000, run, dir, decel, shutoff});
  endtask
  task wr(input [4:0] s, input [15:0] d);
    begin
      wen = 1; wsel = s; wdat = d;
      tick(1);
      rf = refused;
      wen = 0;
      tick(1);
    end
  endtask
  // Alternate decel of 9999 follows the alternate accel
  function [15:0] exp_act(input integer j, input s);
    exp_act = !s ? val[j+1] : (j == 3 && val[11] == 16'd9999) ? val[10] : val[j+8];
  endfunction
  task chk_act(input s);
    integer j;
    for (j = 0; j < 7; j = j + 1)
      chk("act", exp_act(j, s), act[j]);
  endtask
  task halt;
    begin
      fwd = 0; rev = 0; shut = 0; aux = 3'h0;
      tick(2600);
      stp = 1;
      tick(3);
      stp = 0;
      tick(1);
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 95000)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial
  begin
    seed = $urandom(29);
    tick(20);
    rstn = 1;
    tick(1);
    for (i = 0; i < 15; i = i + 1)
      val[i] = 16'h0000;
    val[11] = 16'd9999;
    cmd(4'h0);
    chk_act(0);
    for (i = 1; i < 15; i = i + 1)
    begin
      val[i] = 16'($urandom);
      wr(5'(i), val[i]);
    end
    chk_act(0);
    ugrs = 16'(1 + $urandom % 65534);
    wr(5'd1, ~val[1]);
    chk("refused", 1, rf);
    ugrs = 16'h0000;
    chk_act(0);
    sec = 1;
    tick(2600);
    chk("second", 1, second);
    chk_act(1);
    val[11] = 16'd9999;
    wr(5'd11, val[11]);
    chk_act(1);
    sec = 0;
    tick(2600);
    chk_act(0);
    fwd = 1;
    tick(2600);
    cmd(4'b1000);
    rev = 1;
    tick(2600);
    cmd(4'b0010);
    fwd = 0;
    tick(2600);
    cmd(4'b1100);
    rev = 0;
    tick(2600);
    cmd(4'b0110);
    halt;
    wr(5'd0, 16'd8888);
    fwd = 1; rev = 1;
    tick(2600);
    cmd(4'b1100);
    fwd = 0;
    tick(2600);
    cmd(4'b0110);
    halt;
    for (k = 0; k < 2; k = k + 1)
    begin
      n = 1 + $urandom % 4;
      wr(5'd0, 16'(k ? 1000 + n : n));
      fwd = 1;
      tick(2600);
      fwd = 0;
      c = 0;
      while (!decel && c < 3000)
      begin
        tick(1);
        c = c + 1;
      end
      c = 0;
      while (!shutoff && c < 200)
      begin
        tick(1);
        c = c + 1;
      end
      chk("coast", 1, c >= n * CPS - 1 && c <= n * CPS + 1);
      halt;
    end
    wr(5'd0, 16'd9999);
    fwd = 1;
    tick(2600);
    shut = 1;
    tick(2600);
    cmd(4'b0001);
    halt;
    wr(5'd19, 16'd24);
    aux = 3'h1;
    tick(2600);
    fwd = 1;
    tick(2600);
    cmd(4'b0001);
    halt;
    fwd = 1;
    tick(100);
    fwd = 0;
    tick(2600);
    cmd(4'b0000);
    comm = 1;
    tick(2600);
    chk("comm_off", 0, shutoff);
    net = 1;
    tick(2600);
    chk("comm", 1, shutoff);
    comm = 0; net = 0;
    tick(2600);
    print_verdict;
  end
endmodule // drive_start_stop_input_logic_tb
